// ---- rtl/ppb_regs.svh ----
`ifndef PPB_REGS_SVH
`define PPB_REGS_SVH
// register offsets relative to the port base
`define PPB_OFF_DATA 2'h0
`define PPB_OFF_STATUS 2'h1
`define PPB_OFF_CONTROL 2'h2
// reset values
`define PPB_DATA_RST 8'h00
`define PPB_CTRL_RST 8'h04
// pin idle levels loaded into the synchronisers at reset
`define PPB_STAT_IDLE 5'h08
`define PPB_CTL_IDLE 4'hF
// control bit positions
`define PPB_C_STROBE 0
`define PPB_C_LINEFEED 1
`define PPB_C_INIT 2
`define PPB_C_SELIN 3
`define PPB_C_IRQEN 4
`define PPB_C_DIR 5
// status bit positions
`define PPB_S_TIMEOUT 0
`define PPB_S_RSVD 1
`define PPB_S_IRQ 2
`define PPB_S_ERR 3
`define PPB_S_SEL 4
`define PPB_S_PE 5
`define PPB_S_ACK 6
`define PPB_S_BUSY 7
// enhanced cycle time-out, ns, and cycles at 40 ns (least time, rounded up)
`define PPB_TMO_NS 10000
`define PPB_CLK_NS 40
`define PPB_TMO_CYC ((`PPB_TMO_NS + `PPB_CLK_NS - 1) / `PPB_CLK_NS)
`endif

// ---- rtl/ppb_pkg.sv ----
package ppb_pkg;
   // port operating modes
   typedef enum logic [1:0] {
      PPB_COMPAT,
      PPB_BIDIR,
      PPB_ENH
   } ppb_mode_t;
   // printer status inputs, raw pin levels
   typedef struct packed {
      logic busyIn;
      logic ackIn;
      logic paperEndIn;
      logic selectedIn;
      logic errorIn;
   } ppb_stat_t;
   // control pin outputs
   typedef struct packed {
      logic selectInOut;
      logic initOut;
      logic lineFeedOut;
      logic strobeOut;
   } ppb_ctl_t;
endpackage

// ---- rtl/ppb_fifo.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// small synchronous fifo
// ----------------------------------------
module ppb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [AW:0] count;
   logic doWr;
   logic doRd;

   // handshake terms
   assign inReady = (count != (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign doWr = inValid && inReady;
   assign doRd = outValid && outReady;
   assign outData = mem[rdPtr];

   // storage
   always_ff @(posedge mclk) begin
      if (doWr) begin
         mem[wrPtr] <= inData;
      end
   end

   // pointers and fill count
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (doWr) begin
            wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
         end
         if (doRd) begin
            rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
         end
         count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
      end
   end
endmodule

// ---- rtl/ppb_port.sv ----
`timescale 1ns/1ps
`include "ppb_regs.svh"
// What this block does
// - data at 00h, status at 01h read-only, control at 02h.
// - one data byte both ways; direction from control bit 5 plus mode.
// - host read and write strobes trigger data register transfers.
// - compatible mode: write drives lines, read returns latch, direction ignored.
// - bidirectional, direction 0: write drives lines, read returns latch.
// - bidirectional, direction 1: read returns lines, write only latches.
// - data register resets to zero.
// - writes to status register change nothing.
// - status bit 0 reads 1 outside enhanced modes.
// - enhanced: bit 0 cleared on entry, set on time-out, cleared on read.
// - status bit 1 always reads 1.
// - status bit 2 reads 1 outside bidirectional mode.
// - bidirectional with irq enable: bit 2 latches low on ack rise; read restores.
// - status bit 3 shows error input, 0 is error.
// - status bit 4 shows selected input.
// - status bit 5 shows paper-end input.
// - status bit 6 follows acknowledge input.
// - status bit 7 is inverted busy input.
// - control register read/write except bits 5 to 7; drives control outputs.
// - control readback shows pin levels of the four control pins.
// - direction bit is write-only and reads back 1.
// - bidirectional with irq enable: interrupt on trailing edge of acknowledge.
module ppb_port
   import ppb_pkg::*;
#(
   parameter int FIFO_DEPTH = 8,
   parameter int TMO_CYC = `PPB_TMO_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // host i/o strobes
   input wire logic [1:0] hostAddr,
   input wire logic hostRd,
   input wire logic hostWr,
   input wire logic [7:0] hostWrData,
   output logic [7:0] hostRdData,
   output logic hostWrReady,
   // mode select
   input wire ppb_mode_t portMode,
   // enhanced cycle stall from the peripheral side
   input wire logic enhCycleBusy,
   // data lines, three signals
   input wire logic [7:0] dataLinesIn,
   output logic [7:0] dataLinesOut,
   output logic dataLinesOe_b,
   // printer status inputs
   input wire ppb_stat_t statIn,
   // control pins, three signals each
   input wire ppb_ctl_t ctlPinIn,
   output ppb_ctl_t ctlPinOut,
   output logic ctlPinOe_b,
   // interrupt request
   output logic portInterrupt
);
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   ppb_stat_t statMeta;
   ppb_stat_t statSync;
   ppb_ctl_t ctlMeta;
   ppb_ctl_t ctlSync;
   logic [7:0] linesMeta;
   logic [7:0] linesSync;
   logic ackPrev;

   // two flops on every pin input
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         statMeta <= `PPB_STAT_IDLE; // ack idles high, so no false edge after reset
         statSync <= `PPB_STAT_IDLE;
         ctlMeta <= `PPB_CTL_IDLE;
         ctlSync <= `PPB_CTL_IDLE;
         linesMeta <= '0;
         linesSync <= '0;
      end else begin
         statMeta <= statIn;
         statSync <= statMeta;
         ctlMeta <= ctlPinIn;
         ctlSync <= ctlMeta;
         linesMeta <= dataLinesIn;
         linesSync <= linesMeta;
      end
   end

   // edge detector reads only the second stage
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ackPrev <= 1'b1;
      end else begin
         ackPrev <= statSync.ackIn;
      end
   end

   // ----------------------------------------
   // host strobe decode
   // ----------------------------------------
   logic selData;
   logic selStat;
   logic selCtrl;
   logic rdStat;
   logic wrData;
   logic wrCtrl;
   logic fifoOutValid;
   logic [7:0] fifoOutData;
   logic drainReady;

   assign selData = (hostAddr == `PPB_OFF_DATA);
   assign selStat = (hostAddr == `PPB_OFF_STATUS);
   assign selCtrl = (hostAddr == `PPB_OFF_CONTROL);
   assign rdStat = hostRd && selStat;
   assign wrData = hostWr && selData && hostWrReady;
   // status writes decode to nothing
   assign wrCtrl = hostWr && selCtrl;

   // ----------------------------------------
   // data path: host writes queue into the latch
   // ----------------------------------------
   ppb_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) uFifo (
      .mclk(mclk),
      .rst_b(rst_b),
      .inValid(wrData),
      .inReady(hostWrReady),
      .inData(hostWrData),
      .outValid(fifoOutValid),
      .outReady(drainReady),
      .outData(fifoOutData)
   );

   // latch drains only while no enhanced cycle stalls the port
   assign drainReady = !enhCycleBusy;

   logic [7:0] portDataByte;
   logic [7:0] printerControlByte;
   logic dirIn;
   logic drivesLines;

   // output latch, one byte for both directions
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         portDataByte <= `PPB_DATA_RST;
      end else if (fifoOutValid && drainReady) begin
         portDataByte <= fifoOutData;
      end
   end

   // direction only counts in bidirectional-like modes
   assign dirIn = printerControlByte[`PPB_C_DIR] && (portMode != PPB_COMPAT);
   assign drivesLines = !dirIn;
   assign dataLinesOut = portDataByte;
   assign dataLinesOe_b = !drivesLines;

   // ----------------------------------------
   // control register
   // ----------------------------------------
   // direction kept but never read back
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         printerControlByte <= `PPB_CTRL_RST;
      end else if (wrCtrl) begin
         printerControlByte <= hostWrData;
      end
   end

   // active-low pins are the inverse of their bits, init follows its bit
   assign ctlPinOut.strobeOut = !printerControlByte[`PPB_C_STROBE];
   assign ctlPinOut.lineFeedOut = !printerControlByte[`PPB_C_LINEFEED];
   assign ctlPinOut.initOut = printerControlByte[`PPB_C_INIT];
   assign ctlPinOut.selectInOut = !printerControlByte[`PPB_C_SELIN];
   assign ctlPinOe_b = 1'b0;

   // ----------------------------------------
   // status flags
   // ----------------------------------------
   logic timeoutFlag;
   logic irqLatched_b;
   logic enhPrev;
   logic [$clog2(TMO_CYC+1)-1:0] tmoCnt;
   logic tmoHit;
   logic ackRise;
   logic irqArmed;

   assign ackRise = statSync.ackIn && !ackPrev;
   assign irqArmed = (portMode == PPB_BIDIR) && printerControlByte[`PPB_C_IRQEN];
   assign tmoHit = (tmoCnt == ($clog2(TMO_CYC+1))'(TMO_CYC - 1)) && enhCycleBusy;

   // stall counter for enhanced cycles
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tmoCnt <= '0;
      end else if (!enhCycleBusy || portMode != PPB_ENH || tmoHit) begin
         tmoCnt <= '0;
      end else begin
         tmoCnt <= tmoCnt + 1'b1;
      end
   end

   // time-out flag: set wins over the read clear
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         timeoutFlag <= 1'b1;
         enhPrev <= 1'b0;
      end else begin
         enhPrev <= (portMode == PPB_ENH);
         if (portMode == PPB_ENH && tmoHit) begin
            timeoutFlag <= 1'b1;
         end else if (portMode == PPB_ENH && !enhPrev) begin
            timeoutFlag <= 1'b0;
         end else if (rdStat) begin
            timeoutFlag <= 1'b0;
         end
      end
   end

   // irq status, active low, latch wins over read
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irqLatched_b <= 1'b1;
      end else if (irqArmed && ackRise) begin
         irqLatched_b <= 1'b0;
      end else if (rdStat || !irqArmed) begin
         irqLatched_b <= 1'b1;
      end
   end

   // interrupt output mirrors the latched request
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         portInterrupt <= 1'b0;
      end else begin
         portInterrupt <= irqArmed && (!irqLatched_b || ackRise) && !(rdStat && !ackRise);
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   logic [7:0] printerStatusByte;
   logic [7:0] ctrlReadback;
   logic [7:0] next_rdData;

   always_comb begin
      printerStatusByte = 8'h00;
      printerStatusByte[`PPB_S_TIMEOUT] = (portMode == PPB_ENH) ? timeoutFlag : 1'b1;
      printerStatusByte[`PPB_S_RSVD] = 1'b1;
      printerStatusByte[`PPB_S_IRQ] = (portMode == PPB_BIDIR) ? irqLatched_b : 1'b1;
      printerStatusByte[`PPB_S_ERR] = statSync.errorIn;
      printerStatusByte[`PPB_S_SEL] = statSync.selectedIn;
      printerStatusByte[`PPB_S_PE] = statSync.paperEndIn;
      printerStatusByte[`PPB_S_ACK] = statSync.ackIn;
      printerStatusByte[`PPB_S_BUSY] = !statSync.busyIn;
   end

   // pin levels supersede the latch when forced externally
   always_comb begin
      ctrlReadback = printerControlByte;
      ctrlReadback[`PPB_C_STROBE] = !ctlSync.strobeOut;
      ctrlReadback[`PPB_C_LINEFEED] = !ctlSync.lineFeedOut;
      ctrlReadback[`PPB_C_INIT] = ctlSync.initOut;
      ctrlReadback[`PPB_C_SELIN] = !ctlSync.selectInOut;
      ctrlReadback[`PPB_C_DIR] = 1'b1;
      ctrlReadback[7:6] = 2'h3;
   end

   always_comb begin
      case (hostAddr)
         `PPB_OFF_DATA: next_rdData = dirIn ? linesSync : portDataByte;
         `PPB_OFF_STATUS: next_rdData = printerStatusByte;
         `PPB_OFF_CONTROL: next_rdData = ctrlReadback;
         default: next_rdData = 8'hFF;
      endcase
   end

   // read data registered on the read strobe
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         hostRdData <= 8'h00;
      end else if (hostRd) begin
         hostRdData <= next_rdData;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_ackRise;
      !statSync.ackIn ##1 statSync.ackIn;
   endsequence

   property p_statusFixed;
      @(posedge mclk) disable iff (!rst_b) hostRd && selStat |=> hostRdData[`PPB_S_RSVD];
   endproperty
   a_statusFixed: assert property (p_statusFixed) else $error("reserved status bit low");

   property p_dirReadsOne;
      @(posedge mclk) disable iff (!rst_b) hostRd && selCtrl |=> hostRdData[`PPB_C_DIR];
   endproperty
   a_dirReadsOne: assert property (p_dirReadsOne) else $error("direction bit read as 0");

   property p_compatDrives;
      @(posedge mclk) disable iff (!rst_b) portMode == PPB_COMPAT |-> !dataLinesOe_b;
   endproperty
   a_compatDrives: assert property (p_compatDrives) else $error("compatible mode not driving");

   property p_dirInReleases;
      @(posedge mclk) disable iff (!rst_b)
         portMode == PPB_BIDIR && printerControlByte[`PPB_C_DIR] |-> dataLinesOe_b;
   endproperty
   a_dirInReleases: assert property (p_dirInReleases) else $error("lines driven in input dir");

   property p_irqLatch;
      @(posedge mclk) disable iff (!rst_b)
         irqArmed && $stable(portMode) && $stable(printerControlByte) throughout s_ackRise |=> !irqLatched_b;
   endproperty
   a_irqLatch: assert property (p_irqLatch) else $error("ack rise not latched");

   property p_irqOut;
      @(posedge mclk) disable iff (!rst_b) irqArmed && ackRise && !rdStat |=> portInterrupt;
   endproperty
   a_irqOut: assert property (p_irqOut) else $error("interrupt missed");

   property p_busyInv;
      @(posedge mclk) disable iff (!rst_b) hostRd && selStat |=> hostRdData[`PPB_S_BUSY] == !$past(statSync.busyIn);
   endproperty
   a_busyInv: assert property (p_busyInv) else $error("busy not inverted");

   property p_bit0Compat;
      @(posedge mclk) disable iff (!rst_b) hostRd && selStat && portMode != PPB_ENH |=> hostRdData[`PPB_S_TIMEOUT];
   endproperty
   a_bit0Compat: assert property (p_bit0Compat) else $error("status bit 0 low outside enhanced");

   property p_ctrlWrite;
      @(posedge mclk) disable iff (!rst_b) wrCtrl |=> ctlPinOut.initOut == $past(hostWrData[`PPB_C_INIT]);
   endproperty
   a_ctrlWrite: assert property (p_ctrlWrite) else $error("init pin not following write");

   property p_statWriteIgnored;
      @(posedge mclk) disable iff (!rst_b) hostWr && selStat |=> $stable(printerControlByte);
   endproperty
   a_statWriteIgnored: assert property (p_statWriteIgnored) else $error("status write changed control");

   property p_irqBitHigh;
      @(posedge mclk) disable iff (!rst_b) hostRd && selStat && portMode != PPB_BIDIR |=> hostRdData[`PPB_S_IRQ];
   endproperty
   a_irqBitHigh: assert property (p_irqBitHigh) else $error("status bit 2 low");

   property p_irqReadRestores;
      @(posedge mclk) disable iff (!rst_b) rdStat && !(irqArmed && ackRise) |=> irqLatched_b;
   endproperty
   a_irqReadRestores: assert property (p_irqReadRestores) else $error("irq bit not restored");

   property p_ackFollows;
      @(posedge mclk) disable iff (!rst_b) hostRd && selStat |=> hostRdData[`PPB_S_ACK] == $past(statSync.ackIn);
   endproperty
   a_ackFollows: assert property (p_ackFollows) else $error("ack bit not following pin");

   property p_dir0Drives;
      @(posedge mclk) disable iff (!rst_b)
         portMode == PPB_BIDIR && !printerControlByte[`PPB_C_DIR] |-> !dataLinesOe_b;
   endproperty
   a_dir0Drives: assert property (p_dir0Drives) else $error("lines released in output dir");

   // entry into enhanced mode takes two samples of the mode
   sequence s_enterEnh;
      portMode != PPB_ENH ##1 portMode == PPB_ENH;
   endsequence

   property p_enhEntryClears;
      @(posedge mclk) disable iff (!rst_b) s_enterEnh |=> !timeoutFlag;
   endproperty
   a_enhEntryClears: assert property (p_enhEntryClears) else $error("time-out flag kept on entry");

   property p_tmoReadClears;
      @(posedge mclk) disable iff (!rst_b) rdStat && !(portMode == PPB_ENH && tmoHit) |=> !timeoutFlag;
   endproperty
   a_tmoReadClears: assert property (p_tmoReadClears) else $error("time-out flag kept on read");

   // a lone data write reaches the latch two edges later
   sequence s_writeAlone;
      wrData && !fifoOutValid ##1 !enhCycleBusy;
   endsequence

   property p_writeDrains;
      @(posedge mclk) disable iff (!rst_b) s_writeAlone |=> portDataByte == $past(hostWrData, 2);
   endproperty
   a_writeDrains: assert property (p_writeDrains) else $error("written byte not latched");
endmodule

// ---- test/ppb_printer.sv ----
`timescale 1ns/1ps
// ----
// printer model on the far side of the port
// ----
module ppb_printer
   import ppb_pkg::*;
#(
   parameter int ACK_LEN = 4
) (
   // clock
   input wire logic mclk,
   // port pins
   input wire logic [7:0] dataLinesOut,
   input wire logic dataLinesOe_b,
   input wire ppb_ctl_t ctlPinOut,
   output logic [7:0] dataLinesIn,
   output ppb_ctl_t ctlPinIn,
   output ppb_stat_t statIn,
   // bench knobs
   input wire logic [7:0] periByte,
   input wire logic [2:0] periLevels,
   input wire logic forceEn,
   input wire ppb_ctl_t forceVal,
   output logic [7:0] gotByte
);
   logic [7:0] cnt = 8'h00;
   logic strobePrev = 1'b1;
   // wire levels: released lines carry our own byte, never the stale latch
   assign dataLinesIn = dataLinesOe_b ? periByte : dataLinesOut;
   assign ctlPinIn = forceEn ? forceVal : ctlPinOut;
   // take a byte on strobe fall, stay busy, pulse ack low at the end
   always_ff @(posedge mclk) begin
      strobePrev <= ctlPinIn.strobeOut;
      if (strobePrev && !ctlPinIn.strobeOut && cnt == 8'h00) begin
         gotByte <= dataLinesIn;
         cnt <= 8'(3 * ACK_LEN);
      end else if (cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
      end
   end
   // busy covers the whole character, ack only its tail
   assign statIn.busyIn = cnt != 8'h00;
   assign statIn.ackIn = !(cnt != 8'h00 && cnt <= 8'(ACK_LEN));
   assign {statIn.paperEndIn, statIn.selectedIn, statIn.errorIn} = periLevels;
endmodule

// ---- test/printer_port_basic_registers_bench.sv ----
`timescale 1ns/1ps
// ----
// port bench
// ----
module printer_port_basic_registers_bench;
   import ppb_pkg::*;
   logic mclk = 1'b0, rst_b = 1'b0, hostRd = 1'b0, hostWr = 1'b0;
   logic [1:0] hostAddr = 2'h0;
   logic [7:0] hostWrData = 8'h00, periByte = 8'h00, hostRdData, dataLinesIn, dataLinesOut, gotByte, v, w;
   logic hostWrReady, dataLinesOe_b, ctlPinOe_b, portInterrupt, forceEn = 1'b0, pend = 1'b0;
   logic enhCycleBusy = 1'b0;
   logic [2:0] periLevels = 3'h5;
   logic [31:0] seed = 32'h250A;
   ppb_mode_t portMode = PPB_COMPAT;
   ppb_stat_t statIn;
   ppb_ctl_t ctlPinIn, ctlPinOut, forceVal = '0;
   logic [7:0] expQ[$];
   int errors = 0, checkCount = 0, i;

   // short time-out keeps the enhanced test brief
   ppb_port #(.TMO_CYC(4)) ppb_port_inst (.mclk, .rst_b, .hostAddr, .hostRd, .hostWr, .hostWrData,
      .hostRdData, .hostWrReady, .portMode, .enhCycleBusy, .dataLinesIn, .dataLinesOut, .dataLinesOe_b,
      .statIn, .ctlPinIn, .ctlPinOut, .ctlPinOe_b, .portInterrupt);
   ppb_printer #(.ACK_LEN(8)) ppb_printer_inst (.mclk, .dataLinesOut, .dataLinesOe_b, .ctlPinOut,
      .dataLinesIn, .ctlPinIn, .statIn, .periByte, .periLevels, .forceEn, .forceVal, .gotByte);

   // 25 MHz clock
   always #20 mclk = ~mclk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // idle printer status: not busy, ack high
   function automatic logic [7:0] st(input logic b2, input logic b0);
      return {2'b11, periLevels, b2, 1'b1, b0};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checkCount++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk);
      hostAddr <= a;
      hostWrData <= d;
      hostWr <= 1'b1;
      @(posedge mclk);
      hostWr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge mclk);
      hostAddr <= a;
      hostRd <= 1'b1;
      expQ.push_back(e);
      @(posedge mclk);
      hostRd <= 1'b0;
   endtask
   task automatic mode(input ppb_mode_t m);
      @(posedge mclk);
      portMode <= m;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checkCount, errors);
      if (errors == 0 && checkCount > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // read data lands the cycle after the strobe; match it to the oldest note
   always @(negedge mclk) begin
      if (pend) begin
         check(hostRdData, expQ.pop_front());
      end
      pend = hostRd;
   end

   // watchdog, far beyond the fewer than 200 cycles the tests need
   initial begin
      cyc(3000);
      errors++;
      close_out();
   end

   // main sequence
   initial begin
      cyc(3);
      rst_b <= 1'b1;
      rd(2'h0, 8'h00);
      rd(2'h2, 8'hE4);
      @(negedge mclk);
      check({4'h0, ctlPinOut}, 8'h0F);
      check({7'h0, ctlPinOe_b}, 8'h00);
      for (i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         periLevels <= seed[2:0];
         cyc(3);
         rd(2'h1, st(1'b1, 1'b1));
      end
      $display("reset and status done");
      // compatible: direction bit has no effect
      seed = lfsr(seed);
      v = seed[7:0];
      wr(2'h2, 8'h24);
      wr(2'h0, v);
      cyc(3);
      @(negedge mclk);
      check(dataLinesOut, v);
      check({7'h0, dataLinesOe_b}, 8'h00);
      rd(2'h0, v);
      wr(2'h1, 8'h00);
      wr(2'h3, 8'h5A);
      rd(2'h3, 8'hFF);
      rd(2'h0, v);
      rd(2'h1, st(1'b1, 1'b1));
      $display("compatible done");
      // bidirectional, output then input direction
      mode(PPB_BIDIR);
      wr(2'h2, 8'h04);
      seed = lfsr(seed);
      w = seed[15:8];
      periByte <= seed[23:16];
      wr(2'h0, w);
      cyc(3);
      @(negedge mclk);
      check(dataLinesOut, w);
      rd(2'h0, w);
      wr(2'h2, 8'h24);
      wr(2'h0, v);
      cyc(3);
      @(negedge mclk);
      check({7'h0, dataLinesOe_b}, 8'h01);
      rd(2'h0, periByte);
      rd(2'h2, 8'hE4);
      wr(2'h2, 8'h04);
      cyc(2);
      @(negedge mclk);
      check(dataLinesOut, v);
      $display("bidirectional done");
      // pins forced from outside after parking the control bits
      wr(2'h2, 8'h04);
      forceVal <= 4'b0011;
      forceEn <= 1'b1;
      cyc(4);
      rd(2'h2, 8'hE8);
      forceEn <= 1'b0;
      cyc(4);
      $display("readback done");
      // strobe a byte out and catch the acknowledge
      wr(2'h2, 8'h15);
      @(negedge mclk);
      check({4'h0, ctlPinOut}, 8'h0E);
      cyc(5);
      rd(2'h1, {2'b01, periLevels, 3'b111});
      wr(2'h2, 8'h14);
      for (i = 0; i < 100 && statIn.ackIn; i++) @(negedge mclk);
      cyc(2);
      rd(2'h1, {2'b00, periLevels, 3'b111});
      for (i = 0; i < 100 && !portInterrupt; i++) @(negedge mclk);
      check({7'h0, portInterrupt}, 8'h01);
      check(gotByte, v);
      rd(2'h1, st(1'b0, 1'b1));
      rd(2'h1, st(1'b1, 1'b1));
      @(negedge mclk);
      check({7'h0, portInterrupt}, 8'h00);
      $display("interrupt done");
      // enhanced time-out flag
      wr(2'h2, 8'h04);
      mode(PPB_ENH);
      cyc(2);
      rd(2'h1, st(1'b1, 1'b0));
      enhCycleBusy <= 1'b1;
      cyc(6);
      enhCycleBusy <= 1'b0;
      rd(2'h1, st(1'b1, 1'b1));
      rd(2'h1, st(1'b1, 1'b0));
      $display("time-out done");
      // fifo fills while draining is stalled
      mode(PPB_COMPAT);
      enhCycleBusy <= 1'b1;
      for (i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         wr(2'h0, seed[7:0]);
         @(negedge mclk);
         check({7'h0, hostWrReady}, {7'h0, i < 7});
      end
      wr(2'h0, ~seed[7:0]);
      enhCycleBusy <= 1'b0;
      cyc(20);
      @(negedge mclk);
      check(dataLinesOut, seed[7:0]);
      $display("fifo done");
      close_out();
   end
endmodule
